// ==== spi_control_status_frame.sv ====
// serial port control, status and frame logic with register access
`timescale 1ns/1ps
module spi_control_status_frame #(
  parameter int FIFO_DEPTH = spi_frame_pkg::fifo_depth
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr_en,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_rd_en,
  output logic [7:0] sfr_rdata,
  input wire logic bit_wr_en,
  input wire logic [2:0] bit_index,
  input wire logic bit_value,
  input wire logic sck_in,
  output logic sck_out,
  output logic sck_oe_n,
  input wire logic mosi_in,
  output logic mosi_out,
  output logic mosi_oe_n,
  input wire logic miso_in,
  output logic miso_out,
  output logic miso_oe_n,
  input wire logic slave_select_n,
  output logic irq_req
);
  typedef struct packed {
    logic [7:0] ctl;
    logic [spi_frame_pkg::frame_w-1:0] frame;
    logic [7:0] rate;
    spi_frame_pkg::mstate_t mst;
    logic [7:0] div;
    logic [3:0] bits_left;
    logic [7:0] shift;
    logic rx_bit;
    logic sck_prev;
    logic nss_prev;
    logic sck_out;
    logic sck_oe_n;
    logic mosi_oe_n;
    logic miso_oe_n;
    logic [7:0] rdata;
    logic irq;
    logic push;
    logic [7:0] push_data;
  } state_t;

  state_t q;
  state_t d;

  logic [3:0] pins_s;
  logic sck_s;
  logic mosi_s;
  logic miso_s;
  logic nss_s;
  logic fifo_in_ready;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] fifo_out_data;

  logic set_done;
  logic set_write_collision_flag;
  logic set_mode_fault_flag;
  logic set_ovr;
  logic master_start;
  logic master_fall;
  logic master_end;
  logic data_wr;
  logic slave_end;

  // pins retimed first; select inverted so reset reads it idle
  spi_sync2 #(
    .WIDTH(4)
  ) u_sync (
    .clk(clk),
    .rst(rst),
    .din({sck_in, mosi_in, miso_in, ~slave_select_n}),
    .dout(pins_s)
  );

  assign sck_s = pins_s[3];
  assign mosi_s = pins_s[2];
  assign miso_s = pins_s[1];
  assign nss_s = ~pins_s[0];

  spi_rx_fifo #(
    .WIDTH(spi_frame_pkg::data_w),
    .DEPTH(FIFO_DEPTH)
  ) u_rx_fifo (
    .clk(clk),
    .rst(rst),
    .in_valid(q.push),
    .in_ready(fifo_in_ready),
    .in_data(q.push_data),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop),
    .out_data(fifo_out_data)
  );

  always_comb begin
    logic [7:0] ctl_w;
    logic pe;
    logic me;
    logic master_on;
    logic slave_on;
    logic in_progress;
    logic busy_n;
    d = q;
    ctl_w = q.ctl;
    pe = q.ctl[spi_frame_pkg::pe_pos];
    me = q.ctl[spi_frame_pkg::me_pos];
    master_on = pe & me;
    slave_on = pe & ~me;
    in_progress = q.ctl[spi_frame_pkg::busy_pos] | (slave_on & ~nss_s);
    busy_n = q.ctl[spi_frame_pkg::busy_pos];
    set_done = 1'b0;
    set_write_collision_flag = 1'b0;
    set_mode_fault_flag = 1'b0;
    set_ovr = 1'b0;
    master_start = 1'b0;
    master_fall = 1'b0;
    master_end = 1'b0;
    slave_end = 1'b0;
    fifo_pop = 1'b0;
    d.push = 1'b0;
    data_wr = sfr_wr_en && (sfr_addr == spi_frame_pkg::data_addr);
    d.sck_prev = sck_s;
    d.nss_prev = nss_s;

    if (sfr_wr_en && sfr_addr == spi_frame_pkg::ctl_addr) begin
      ctl_w = sfr_wdata;
    end else if (bit_wr_en) begin
      ctl_w[bit_index] = bit_value;
    end
    if (sfr_wr_en && sfr_addr == spi_frame_pkg::cfg_addr) begin
      d.frame = sfr_wdata[spi_frame_pkg::frame_w-1:0];
    end
    if (sfr_wr_en && sfr_addr == spi_frame_pkg::rate_addr) begin
      d.rate = sfr_wdata;
    end

    // a write during a frame is dropped; shifter keeps running
    if (data_wr && in_progress) begin
      set_write_collision_flag = 1'b1;
    end else if (data_wr && pe) begin
      d.shift = sfr_wdata;
      if (master_on) begin
        master_start = 1'b1;
        d.mst = spi_frame_pkg::st_low;
        d.div = q.rate;
        d.bits_left = 4'({1'b0, q.frame}) + spi_frame_pkg::one_bit;
        busy_n = 1'b1;
      end
    end

    case (q.mst)
      spi_frame_pkg::st_idle: begin
      end
      spi_frame_pkg::st_low: begin
        if (q.div == '0) begin
          d.sck_out = 1'b1;
          d.div = q.rate;
          d.mst = spi_frame_pkg::st_high;
        end else begin
          d.div = q.div - spi_frame_pkg::div_step;
        end
      end
      spi_frame_pkg::st_high: begin
        if (q.div == '0) begin
          // sample late in the high phase so the retimed miso has settled
          master_fall = 1'b1;
          d.sck_out = 1'b0;
          d.shift = {q.shift[6:0], miso_s};
          d.bits_left = q.bits_left - spi_frame_pkg::one_bit;
          d.div = q.rate;
          if (q.bits_left == spi_frame_pkg::one_bit) begin
            master_end = 1'b1;
            d.mst = spi_frame_pkg::st_idle;
            busy_n = 1'b0;
            set_done = 1'b1;
            d.push = 1'b1;
            d.push_data = {q.shift[6:0], miso_s};
          end else begin
            d.mst = spi_frame_pkg::st_low;
          end
        end else begin
          d.div = q.div - spi_frame_pkg::div_step;
        end
      end
      default: begin
        d.mst = spi_frame_pkg::st_idle;
      end
    endcase

    // slave side: frame length field plays no part here
    if (slave_on && !nss_s) begin
      if (spi_frame_pkg::rising(sck_s, q.sck_prev)) begin
        d.rx_bit = mosi_s;
      end
      if (spi_frame_pkg::falling(sck_s, q.sck_prev)) begin
        d.shift = {q.shift[6:0], q.rx_bit};
      end
    end
    if (slave_on && spi_frame_pkg::rising(nss_s, q.nss_prev)) begin
      slave_end = 1'b1;
      set_done = 1'b1;
      d.push = 1'b1;
      d.push_data = q.shift;
    end

    // full buffer refuses the byte; older bytes stay readable
    if (q.push && !fifo_in_ready) begin
      set_ovr = 1'b1;
    end

    if (master_on && !nss_s) begin
      set_mode_fault_flag = 1'b1;
      ctl_w[spi_frame_pkg::me_pos] = 1'b0;
      ctl_w[spi_frame_pkg::pe_pos] = 1'b0;
    end
    if (set_mode_fault_flag || !ctl_w[spi_frame_pkg::pe_pos]) begin
      d.mst = spi_frame_pkg::st_idle;
      d.sck_out = 1'b0;
      busy_n = 1'b0;
      set_done = set_done & ~master_end;
      d.push = d.push & ~master_end;
      master_end = 1'b0;
    end

    // hardware set wins over a software clear in the same cycle
    d.ctl = ctl_w;
    d.ctl[spi_frame_pkg::done_pos] = ctl_w[spi_frame_pkg::done_pos] | set_done;
    d.ctl[spi_frame_pkg::write_collision_flag_pos] = ctl_w[spi_frame_pkg::write_collision_flag_pos] | set_write_collision_flag;
    d.ctl[spi_frame_pkg::mode_fault_flag_pos] = ctl_w[spi_frame_pkg::mode_fault_flag_pos] | set_mode_fault_flag;
    d.ctl[spi_frame_pkg::ovr_pos] = ctl_w[spi_frame_pkg::ovr_pos] | set_ovr;
    d.ctl[spi_frame_pkg::busy_pos] = busy_n;
    d.ctl[spi_frame_pkg::slave_selected_flag_pos] = ctl_w[spi_frame_pkg::pe_pos] &
      ~ctl_w[spi_frame_pkg::me_pos] & ~nss_s;
    d.irq = |d.ctl[spi_frame_pkg::flag_hi:spi_frame_pkg::flag_lo];

    d.sck_oe_n = ~(ctl_w[spi_frame_pkg::pe_pos] &
      ctl_w[spi_frame_pkg::me_pos]);
    d.mosi_oe_n = d.sck_oe_n;
    d.miso_oe_n = ~(ctl_w[spi_frame_pkg::pe_pos] &
      ~ctl_w[spi_frame_pkg::me_pos] & ~nss_s);

    if (sfr_rd_en) begin
      case (sfr_addr)
        spi_frame_pkg::ctl_addr: d.rdata = q.ctl;
        spi_frame_pkg::cfg_addr: d.rdata = {5'h00, q.frame};
        spi_frame_pkg::rate_addr: d.rdata = q.rate;
        spi_frame_pkg::data_addr: begin
          d.rdata = fifo_out_valid ? fifo_out_data : 8'h00;
          fifo_pop = fifo_out_valid;
        end
        default: d.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
      q.ctl <= spi_frame_pkg::ctl_reset;
      q.frame <= spi_frame_pkg::frame_reset;
      q.rate <= spi_frame_pkg::rate_reset;
      q.mst <= spi_frame_pkg::st_idle;
      q.nss_prev <= 1'b1;
      q.sck_oe_n <= 1'b1;
      q.mosi_oe_n <= 1'b1;
      q.miso_oe_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign sfr_rdata = q.rdata;
  assign sck_out = q.sck_out;
  assign sck_oe_n = q.sck_oe_n;
  assign mosi_out = q.shift[7];
  assign mosi_oe_n = q.mosi_oe_n;
  assign miso_out = q.shift[7];
  assign miso_oe_n = q.miso_oe_n;
  assign irq_req = q.irq;

  // helper: falling sck edges counted per master frame
  logic [3:0] chk_falls_q;
  logic [3:0] chk_len_q;
  always_ff @(posedge clk) begin
    if (rst || master_start) begin
      chk_falls_q <= '0;
      chk_len_q <= 4'({1'b0, q.frame}) + spi_frame_pkg::one_bit;
    end else if (master_fall) begin
      chk_falls_q <= chk_falls_q + spi_frame_pkg::one_bit;
    end
  end

  chk_frame_len: assert property (
    @(posedge clk) disable iff (rst)
    master_end |-> (chk_falls_q + spi_frame_pkg::one_bit) == chk_len_q)
    else $error("master frame length differs from field plus one");

  chk_done_sticky: assert property (
    @(posedge clk) disable iff (rst)
    (q.ctl[spi_frame_pkg::done_pos] && !sfr_wr_en && !bit_wr_en)
    |=> q.ctl[spi_frame_pkg::done_pos])
    else $error("done flag dropped without software write");

  chk_write_collision_flag_set: assert property (
    @(posedge clk) disable iff (rst)
    (data_wr && q.ctl[spi_frame_pkg::busy_pos])
    |=> q.ctl[spi_frame_pkg::write_collision_flag_pos] && q.irq)
    else $error("collision flag not set by write during transfer");

  chk_write_collision_flag_keep: assert property (
    @(posedge clk) disable iff (rst)
    (data_wr && q.ctl[spi_frame_pkg::busy_pos] && !set_mode_fault_flag &&
     q.ctl[spi_frame_pkg::pe_pos]) |=> q.bits_left <= $past(q.bits_left))
    else $error("colliding write restarted the transfer");

  chk_mode_fault_flag_off: assert property (
    @(posedge clk) disable iff (rst)
    set_mode_fault_flag |=> q.ctl[spi_frame_pkg::mode_fault_flag_pos] &&
      !q.ctl[spi_frame_pkg::me_pos] && !q.ctl[spi_frame_pkg::pe_pos] &&
      q.sck_oe_n)
    else $error("mode fault did not take port off line");

  chk_overrun_set: assert property (
    @(posedge clk) disable iff (rst)
    (q.push && !fifo_in_ready) |=> q.ctl[spi_frame_pkg::ovr_pos])
    else $error("overrun flag not set on full buffer");

  chk_busy_end: assert property (
    @(posedge clk) disable iff (rst)
    master_end |=> !q.ctl[spi_frame_pkg::busy_pos] ##0
      q.ctl[spi_frame_pkg::done_pos] ##1 q.push == 1'b0)
    else $error("busy not cleared with done at frame end");

  chk_slave_selected_flag_track: assert property (
    @(posedge clk) disable iff (rst)
    (q.ctl[spi_frame_pkg::pe_pos] && !q.ctl[spi_frame_pkg::me_pos] &&
     !sfr_wr_en && !bit_wr_en && $stable(nss_s))
    |=> q.ctl[spi_frame_pkg::slave_selected_flag_pos] == !$past(nss_s))
    else $error("slave selected flag does not follow select");

  chk_role_pins: assert property (
    @(posedge clk) disable iff (rst)
    1'b1 |-> q.sck_oe_n == !(q.ctl[spi_frame_pkg::pe_pos] &&
      q.ctl[spi_frame_pkg::me_pos]))
    else $error("clock drive does not match master role");

  chk_reset_zero: assert property (
    @(posedge clk) $past(rst) && !rst |-> q.ctl == spi_frame_pkg::ctl_reset)
    else $error("control register not zero after reset");

  chk_slave_done: assert property (
    @(posedge clk) disable iff (rst)
    slave_end |=> q.ctl[spi_frame_pkg::done_pos] ##1 !q.push)
    else $error("slave done not set on select release");
endmodule

// ==== spi_control_status_frame_bench.sv ====
// self-checking bench for the serial port control and status block
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
  end \
end
module spi_control_status_frame_bench;
  localparam logic [7:0] a_ctl = spi_frame_pkg::ctl_addr;
  localparam logic [7:0] a_cfg = spi_frame_pkg::cfg_addr;
  localparam logic [7:0] a_dat = spi_frame_pkg::data_addr;
  localparam logic [7:0] a_rate = spi_frame_pkg::rate_addr;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic wr_en = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic rd_en = 1'b0;
  logic bwr = 1'b0;
  logic [2:0] bidx = 3'h0;
  logic bval = 1'b0;
  logic [7:0] rdata;
  logic sck_out, sck_oe_n, mosi_out, mosi_oe_n, miso_out, miso_oe_n, irq;
  logic m_sck, m_mosi, m_miso, m_ssn_n;
  wire sck_line = !sck_oe_n ? sck_out : m_sck;
  wire mosi_line = !mosi_oe_n ? mosi_out : m_mosi;
  wire miso_line = !miso_oe_n ? miso_out : m_miso;
  // far side plays slave whenever the block drives the clock
  wire as_slave = !sck_oe_n;
  int fails = 0;
  int num_checks = 0;
  int sck_rises = 0;
  logic [7:0] v;
  logic [7:0] e;
  logic [7:0] t;
  logic [7:0] s;
  always #12.5 clk = ~clk;
  always @(posedge sck_out) sck_rises++;
  spi_control_status_frame dut (
    .clk(clk), .rst(rst), .sfr_addr(addr), .sfr_wr_en(wr_en),
    .sfr_wdata(wdata), .sfr_rd_en(rd_en), .sfr_rdata(rdata),
    .bit_wr_en(bwr), .bit_index(bidx), .bit_value(bval),
    .sck_in(sck_line), .sck_out(sck_out), .sck_oe_n(sck_oe_n),
    .mosi_in(mosi_line), .mosi_out(mosi_out), .mosi_oe_n(mosi_oe_n),
    .miso_in(miso_line), .miso_out(miso_out), .miso_oe_n(miso_oe_n),
    .slave_select_n(m_ssn_n), .irq_req(irq));
  spi_far_model far (
    .as_slave(as_slave), .sck_line(sck_line), .mosi_line(mosi_line),
    .miso_line(miso_line), .m_sck(m_sck), .m_mosi(m_mosi),
    .m_miso(m_miso), .m_ssn_n(m_ssn_n));
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #1 wr_en = 1'b0;
  endtask
  task automatic bw(input logic [2:0] i, input logic b);
    @(posedge clk);
    #1 bidx = i;
    bval = b;
    bwr = 1'b1;
    @(posedge clk);
    #1 bwr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 addr = a;
    rd_en = 1'b1;
    @(posedge clk);
    #1 rd_en = 1'b0;
    @(posedge clk);
    #1 d = rdata;
  endtask
  // one master frame; polls busy with a bounded count
  task automatic mframe(input logic [7:0] tx, input logic [7:0] sv,
                        input logic col, output logic [7:0] c);
    far.load(sv);
    sck_rises = 0;
    wr(a_dat, tx);
    if (col) wr(a_dat, ~tx);
    rd(a_ctl, c);
    `CHK(c[spi_frame_pkg::busy_pos], 1'b1)
    for (int k = 0; k < 200 && c[3]; k++) rd(a_ctl, c);
    // done lands as busy drops; overrun lands one cycle later
    repeat (3) @(posedge clk);
    rd(a_ctl, c);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #2000000;
    fails++;
    conclude();
  end
  initial begin
    repeat (4) @(posedge clk);
    #1 rst = 1'b0;
    rd(a_ctl, v);
    `CHK(v, 8'h00)
    rd(a_cfg, v);
    `CHK(v, 8'h07)
    rd(8'h55, v);
    `CHK(v, 8'h00)
    bw(3'h3, 1'b1);
    rd(a_ctl, v);
    `CHK(v, 8'h00)
    `CHK(sck_oe_n, 1'b1)
    wr(a_rate, 8'h02);
    bw(3'h0, 1'b1);
    bw(3'h1, 1'b1);
    @(posedge clk);
    #1 `CHK(sck_oe_n, 1'b0)
    for (int f = 0; f < 8; f++) begin
      t = 8'hc3 ^ f[7:0];
      s = 8'h5a + f[7:0];
      wr(a_cfg, f[7:0]);
      mframe(t, s, f == 7, v);
      `CHK(sck_rises, f + 1)
      `CHK(v, (f == 7) ? 8'hc3 : 8'h83)
      `CHK(irq, 1'b1)
      e = (t << (f + 1)) | (s >> (7 - f));
      rd(a_dat, v);
      `CHK(v, e)
      e = (s << (f + 1)) | (t >> (7 - f));
      `CHK(far.sreg, e)
      wr(a_ctl, 8'h03);
      rd(a_ctl, v);
      `CHK(v, 8'h03)
    end
    // fill the buffer past its depth without reading
    wr(a_cfg, 8'h07);
    for (int i = 0; i < 33; i++) begin
      mframe(8'h11, 8'h40 + i[7:0], 1'b0, v);
      `CHK(v[spi_frame_pkg::ovr_pos], i == 32)
    end
    for (int i = 0; i < 33; i++) begin
      rd(a_dat, v);
      `CHK(v, (i < 32) ? 8'h40 + i[7:0] : 8'h00)
    end
    wr(a_ctl, 8'h03);
    far.sel(1'b0);
    repeat (6) @(posedge clk);
    rd(a_ctl, v);
    `CHK(v, 8'h20)
    `CHK(sck_oe_n, 1'b1)
    `CHK(irq, 1'b1)
    far.sel(1'b1);
    wr(a_ctl, 8'h02);
    sck_rises = 0;
    wr(a_dat, 8'h77);
    repeat (20) @(posedge clk);
    rd(a_ctl, v);
    `CHK(v, 8'h02)
    `CHK(sck_rises, 0)
    // slave role: far side clocks one byte with frame field at one bit
    wr(a_cfg, 8'h00);
    wr(a_ctl, 8'h01);
    wr(a_dat, 8'h3c);
    rd(a_ctl, v);
    `CHK(v, 8'h01)
    far.sel(1'b0);
    repeat (4) @(posedge clk);
    rd(a_ctl, v);
    `CHK(v, 8'h05)
    far.shift8(8'h96);
    far.sel(1'b1);
    repeat (6) @(posedge clk);
    rd(a_ctl, v);
    `CHK(v, 8'h81)
    rd(a_dat, v);
    `CHK(v, 8'h96)
    `CHK(far.rxm, 8'h3c)
    conclude();
  end
endmodule

// ==== spi_far_model.sv ====
// far-side serial device: slave to the block's master, master to its slave
`timescale 1ns/1ps
module spi_far_model (
  input wire logic as_slave,
  input wire logic sck_line,
  input wire logic mosi_line,
  input wire logic miso_line,
  output logic m_sck,
  output logic m_mosi,
  output logic m_miso,
  output logic m_ssn_n
);
  logic [7:0] sreg;
  logic [7:0] rxm;
  logic in_bit;
  initial begin
    m_sck = 1'b0;
    m_mosi = 1'b0;
    m_ssn_n = 1'b1;
    sreg = 8'h00;
    rxm = 8'h00;
    in_bit = 1'b0;
  end
  // released miso shows the inverse so a stale bit never passes as data
  assign m_miso = as_slave ? sreg[7] : ~sreg[7];
  always @(posedge sck_line) if (as_slave) in_bit = mosi_line;
  always @(negedge sck_line) if (as_slave) sreg = {sreg[6:0], in_bit};
  task automatic load(input logic [7:0] v);
    sreg = v;
  endtask
  task automatic sel(input logic v);
    m_ssn_n = v;
  endtask
  // clock stands low between frames; 200 ns per bit, msb first
  task automatic shift8(input logic [7:0] tx);
    for (int i = 7; i >= 0; i--) begin
      m_mosi = tx[i];
      #100 m_sck = 1'b1;
      rxm = {rxm[6:0], miso_line};
      #100 m_sck = 1'b0;
    end
    // select must trail the last fall or the last bit is clipped
    #100 m_mosi = ~m_mosi;
  endtask
endmodule

// ==== spi_frame_pkg.sv ====
// constants and helpers shared by the serial port control block
package spi_frame_pkg;
  localparam logic [7:0] ctl_addr = 8'hf8;
  localparam logic [7:0] cfg_addr = 8'h9a;
  localparam logic [7:0] data_addr = 8'h9b;
  localparam logic [7:0] rate_addr = 8'h9d;

  localparam logic [7:0] ctl_reset = 8'h00;
  localparam logic [2:0] frame_reset = 3'h7;
  localparam logic [7:0] rate_reset = 8'h00;

  localparam int done_pos = 7;
  localparam int write_collision_flag_pos = 6;
  localparam int mode_fault_flag_pos = 5;
  localparam int ovr_pos = 4;
  localparam int busy_pos = 3;
  localparam int slave_selected_flag_pos = 2;
  localparam int me_pos = 1;
  localparam int pe_pos = 0;
  localparam int flag_hi = 7;
  localparam int flag_lo = 4;
  localparam int frame_w = 3;
  localparam int data_w = 8;
  localparam int fifo_depth = 32;

  localparam logic [3:0] one_bit = 4'h1;
  localparam logic [7:0] div_step = 8'h01;

  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_low = 2'b01,
    st_high = 2'b10
  } mstate_t;

  function automatic logic rising(input logic now, input logic was);
    rising = now & ~was;
  endfunction

  function automatic logic falling(input logic now, input logic was);
    falling = ~now & was;
  endfunction
endpackage

// ==== spi_rx_fifo.sv ====
// receive buffer fifo with valid/ready on both sides
`timescale 1ns/1ps
module spi_rx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] cnt_full = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] ptr_last = AW'(DEPTH - 1);
  localparam logic [AW-1:0] ptr_one = AW'(1);
  localparam logic [AW:0] cnt_one = (AW + 1)'(1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_t;

  fifo_t q;
  fifo_t d;
  logic do_push;
  logic do_pop;

  assign in_ready = (q.cnt != cnt_full);
  assign out_valid = (q.cnt != '0);
  assign out_data = q.mem[q.rp];

  always_comb begin
    d = q;
    do_push = in_valid & in_ready;
    do_pop = out_valid & out_ready;
    if (do_push) begin
      d.mem[q.wp] = in_data;
      d.wp = (q.wp == ptr_last) ? '0 : q.wp + ptr_one;
    end
    if (do_pop) begin
      d.rp = (q.rp == ptr_last) ? '0 : q.rp + ptr_one;
    end
    if (do_push && !do_pop) begin
      d.cnt = q.cnt + cnt_one;
    end else if (do_pop && !do_push) begin
      d.cnt = q.cnt - cnt_one;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
endmodule

// ==== spi_sync2.sv ====
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module spi_sync2 #(
  parameter int WIDTH = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } sync_t;

  sync_t q;
  sync_t d;

  always_comb begin
    d.s1 = din;
    d.s2 = q.s1;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign dout = q.s2;
endmodule
